// File: verilog/cbh_pkg.sv
package cbh_pkg;

  // Kind of frame on the link side
  typedef enum logic [1:0] {
    FRM_NONE  = 2'b00,
    FRM_READ  = 2'b01, // read_request_frame
    FRM_WRITE = 2'b10, // write_request_frame
    FRM_ERROR = 2'b11  // error_report_frame
  } cbh_frame_t;

  // Program memory geometry
  localparam int ADDR_W = 15;
  localparam logic [14:0] BLK0_FIRST = 15'h0000;
  localparam logic [14:0] BLK0_LAST = 15'h1fff;
  localparam logic [14:0] BLK1_FIRST = 15'h2000;
  localparam logic [14:0] BLK1_LAST = 15'h3fff;
  localparam logic [14:0] BLK2_FIRST = 15'h4000;
  localparam logic [14:0] BLK2_LAST = 15'h7fff;
  localparam logic [14:0] MEM_LAST = 15'h7fff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // Frame lengths
  localparam logic [3:0] LEN_REQ2 = 4'h2;
  localparam logic [3:0] LEN_JUMP = 4'h4;
  localparam logic [3:0] LEN_ANSWER = 4'h1;

  // Command bytes
  localparam logic [7:0] CMD_ERASE = 8'h00;
  localparam logic [7:0] SEL_BLK0 = 8'h00;
  localparam logic [7:0] SEL_BLK1 = 8'h20;
  localparam logic [7:0] SEL_BLK2 = 8'h40;
  localparam logic [7:0] SEL_FULL = 8'hff;
  localparam logic [7:0] CMD_START_RST = 8'h01;
  localparam logic [7:0] OPT_START_RST = 8'h00;
  localparam logic [7:0] CMD_START_JMP = 8'h03;
  localparam logic [7:0] OPT_START_JMP = 8'h01;
  localparam logic [7:0] ANS_OK = 8'h00;
  localparam logic [7:0] ERR_SECURITY = 8'h00;

  // Configuration read selectors held inside the block
  localparam logic [7:0] GRP_BOOT = 8'h01;
  localparam logic [7:0] ITEM_STAT = 8'h00;
  localparam logic [7:0] ITEM_VEC = 8'h01;
  localparam logic [7:0] ITEM_SEC = 8'h05;

  // Values after reset and after full-chip erase
  localparam logic [7:0] CFG_DEFAULT = 8'hff;

endpackage : cbh_pkg

// File: verilog/cbh_erase_walker.sv
`timescale 1ns/1ns
`default_nettype none
module cbh_erase_walker #(
  parameter int AW = 15
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Request
  input wire logic i_start,
  input wire logic [AW-1:0] i_first,
  input wire logic [AW-1:0] i_last,
  // Status
  output logic o_busy,
  output logic o_done,
  // Memory write port
  output logic [AW-1:0] o_wr_addr
);

  logic [AW-1:0] last;

  // One erased location per clock, first to last inclusive
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_wr_addr <= '0;
      last <= '0;
    end else begin
      o_done <= 1'b0;
      if (i_start && !o_busy) begin
        o_busy <= 1'b1;
        o_wr_addr <= i_first;
        last <= i_last;
      end else if (o_busy) begin
        if (o_wr_addr == last) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          o_wr_addr <= o_wr_addr + 1'b1;
        end
      end
    end
  end

endmodule // cbh_erase_walker
`default_nettype wire

// File: verilog/cbh_command_handler.sv
`timescale 1ns/1ns
`default_nettype none
module cbh_command_handler
  import cbh_pkg::*;
(
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  // Received frame
  input wire logic I_RX_VALID,
  output logic O_RX_READY,
  input wire logic [1:0] I_RX_KIND,
  input wire logic [3:0] I_RX_LEN,
  input wire logic [7:0] I_RX_DATA0,
  input wire logic [7:0] I_RX_DATA1,
  input wire logic [7:0] I_RX_DATA2,
  input wire logic [7:0] I_RX_DATA3,
  // Session and protection levels
  input wire logic I_SESSION_OPEN,
  input wire logic I_READ_PROTECT,
  input wire logic I_PROG_PROTECT,
  // Outside configuration values
  output logic [7:0] O_CFG_GROUP,
  output logic [7:0] O_CFG_ITEM,
  input wire logic [7:0] I_CFG_VALUE,
  // Answer frame
  output logic O_TX_VALID,
  input wire logic I_TX_READY,
  output logic [1:0] O_TX_KIND,
  output logic [3:0] O_TX_LEN,
  output logic [7:0] O_TX_DATA,
  // Program memory write port
  output logic O_MEM_WE,
  output logic [14:0] O_MEM_ADDR,
  output logic [7:0] O_MEM_DATA,
  // Application start
  output logic O_WDT_ENABLE,
  output logic O_JUMP,
  output logic [15:0] O_JUMP_ADDR,
  // Boot configuration bytes
  output logic [7:0] O_BOOT_STATUS_BYTE,
  output logic [7:0] O_SOFTWARE_BOOT_VECTOR,
  output logic [7:0] O_SOFTWARE_SECURITY_BYTE
);
  // Every check below runs on this clock and sleeps in reset
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_ERASE = 3'b010,
    ST_SEND  = 3'b011,
    ST_HALT  = 3'b100
  } cbh_state_t;

  cbh_state_t state, next_state;
  logic take;
  logic take_read;
  logic take_erase_blk;
  logic take_erase_full;
  logic take_bad_erase;
  logic take_wdt;
  logic take_jump;
  logic erase_go;
  logic walk_busy, walk_done;
  logic [14:0] first_addr, last_addr;
  logic [7:0] read_value;

  // First and last address for a block selector
  function automatic logic [29:0] block_range(input logic [7:0] sel);
    unique case (sel)
      SEL_BLK0: block_range = {BLK0_FIRST, BLK0_LAST};
      SEL_BLK1: block_range = {BLK1_FIRST, BLK1_LAST};
      SEL_BLK2: block_range = {BLK2_FIRST, BLK2_LAST};
      default: block_range = {BLK0_FIRST, MEM_LAST};
    endcase
  endfunction

  function automatic logic is_block(input logic [7:0] sel);
    is_block = (sel == SEL_BLK0) || (sel == SEL_BLK1) || (sel == SEL_BLK2);
  endfunction

  // Command decode; a closed session drops every frame silently
  assign O_RX_READY = (state == ST_IDLE);
  assign take = I_RX_VALID && O_RX_READY && I_SESSION_OPEN;
  assign take_read = take && (I_RX_KIND == FRM_READ)
      && (I_RX_LEN == LEN_REQ2);
  wire erase_frame = take && (I_RX_KIND == FRM_WRITE)
      && (I_RX_LEN == LEN_REQ2) && (I_RX_DATA0 == CMD_ERASE);
  assign take_erase_blk = erase_frame && is_block(I_RX_DATA1);
  assign take_erase_full = erase_frame && (I_RX_DATA1 == SEL_FULL);
  assign take_bad_erase = erase_frame && !is_block(I_RX_DATA1)
      && (I_RX_DATA1 != SEL_FULL);
  assign take_wdt = take && (I_RX_KIND == FRM_WRITE)
      && (I_RX_LEN == LEN_REQ2) && (I_RX_DATA0 == CMD_START_RST)
      && (I_RX_DATA1 == OPT_START_RST);
  assign take_jump = take && (I_RX_KIND == FRM_WRITE)
      && (I_RX_LEN == LEN_JUMP) && (I_RX_DATA0 == CMD_START_JMP)
      && (I_RX_DATA1 == OPT_START_JMP);

  // Full erase ignores protection; block erase honours it
  assign erase_go = take_erase_full
      || (take_erase_blk && !I_PROG_PROTECT);
  assign {first_addr, last_addr} = take_erase_full ? {BLK0_FIRST, MEM_LAST}
      : block_range(I_RX_DATA1);

  cbh_erase_walker #(
    .AW(ADDR_W)
  ) u_walker (
    .i_clock(I_CLOCK),
    .i_reset(I_RESET),
    .i_start(erase_go),
    .i_first(first_addr),
    .i_last(last_addr),
    .o_busy(walk_busy),
    .o_done(walk_done),
    .o_wr_addr(O_MEM_ADDR)
  );
  assign O_MEM_WE = walk_busy;
  assign O_MEM_DATA = ERASED_BYTE;

  // Sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (take_read && !I_READ_PROTECT) next_state = ST_FETCH;
        else if (take_read) next_state = ST_SEND;
        else if (erase_go) next_state = ST_ERASE;
        else if (take_erase_blk) next_state = ST_SEND;
        else if (take_wdt) next_state = ST_HALT;
      end
      ST_FETCH: next_state = ST_SEND;
      ST_ERASE: if (walk_done) next_state = ST_SEND;
      ST_SEND: if (I_TX_READY) next_state = ST_IDLE;
      ST_HALT: next_state = ST_HALT; // Only the watchdog reset leaves
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) state <= ST_IDLE;
    else state <= next_state;
  end

  // Boot bytes held here so that full erase can restore them
  always_comb begin
    read_value = I_CFG_VALUE;
    if (O_CFG_GROUP == GRP_BOOT) begin
      if (O_CFG_ITEM == ITEM_STAT) read_value = O_BOOT_STATUS_BYTE;
      else if (O_CFG_ITEM == ITEM_VEC) read_value = O_SOFTWARE_BOOT_VECTOR;
      else if (O_CFG_ITEM == ITEM_SEC) read_value = O_SOFTWARE_SECURITY_BYTE;
    end
  end

  // Read selection is registered to keep the outside lookup off the bus
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      O_CFG_GROUP <= 8'h00;
      O_CFG_ITEM <= 8'h00;
    end else if (take_read) begin
      O_CFG_GROUP <= I_RX_DATA0;
      O_CFG_ITEM <= I_RX_DATA1;
    end
  end

  // Answer frame registers
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      O_TX_VALID <= 1'b0;
      O_TX_KIND <= FRM_NONE;
      O_TX_LEN <= 4'h0;
      O_TX_DATA <= 8'h00;
    end else if (state == ST_IDLE && ((take_read && I_READ_PROTECT)
        || (take_erase_blk && I_PROG_PROTECT))) begin
      O_TX_VALID <= 1'b1;
      O_TX_KIND <= FRM_ERROR;
      O_TX_LEN <= LEN_ANSWER;
      O_TX_DATA <= ERR_SECURITY;
    end else if (state == ST_FETCH) begin
      O_TX_VALID <= 1'b1;
      O_TX_KIND <= FRM_READ;
      O_TX_LEN <= LEN_ANSWER;
      O_TX_DATA <= read_value;
    end else if (state == ST_ERASE && walk_done) begin
      O_TX_VALID <= 1'b1;
      O_TX_KIND <= FRM_WRITE;
      O_TX_LEN <= LEN_ANSWER;
      O_TX_DATA <= ANS_OK;
    end else if (state == ST_SEND && I_TX_READY) begin
      O_TX_VALID <= 1'b0;
    end
  end

  // Boot bytes go back to no-security defaults on full erase
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      O_BOOT_STATUS_BYTE <= CFG_DEFAULT;
      O_SOFTWARE_BOOT_VECTOR <= CFG_DEFAULT;
      O_SOFTWARE_SECURITY_BYTE <= CFG_DEFAULT;
    end else if (take_erase_full) begin
      O_BOOT_STATUS_BYTE <= CFG_DEFAULT;
      O_SOFTWARE_BOOT_VECTOR <= CFG_DEFAULT;
      O_SOFTWARE_SECURITY_BYTE <= CFG_DEFAULT;
    end
  end

  // Start commands: no answer frame is ever queued for them
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      O_WDT_ENABLE <= 1'b0;
      O_JUMP <= 1'b0;
      O_JUMP_ADDR <= 16'h0000;
    end else begin
      O_JUMP <= take_jump;
      if (take_jump) O_JUMP_ADDR <= {I_RX_DATA2, I_RX_DATA3};
      if (take_wdt) O_WDT_ENABLE <= 1'b1;
    end
  end

  // Checks
  sequence error_frame_s;
    O_TX_VALID && O_TX_KIND == FRM_ERROR && O_TX_LEN == LEN_ANSWER
      && O_TX_DATA == ERR_SECURITY;
  endsequence

  sequence no_answer_s;
    !O_TX_VALID [*3];
  endsequence

  read_error_a: assert property (
    take_read && I_READ_PROTECT |=> error_frame_s)
    else $error("protected read not answered with error");

  read_reply_a: assert property (
    take_read && !I_READ_PROTECT |=> !O_TX_VALID ##1 (O_TX_VALID
      && O_TX_KIND == FRM_READ && O_TX_LEN == LEN_ANSWER))
    else $error("read reply malformed or late");

  closed_ignore_a: assert property (
    I_RX_VALID && O_RX_READY && !I_SESSION_OPEN |=> O_RX_READY && !O_MEM_WE
      && !O_TX_VALID && !O_JUMP)
    else $error("frame acted on with session closed");

  block_protect_a: assert property (
    take_erase_blk && I_PROG_PROTECT |=> error_frame_s and !O_MEM_WE)
    else $error("protected block erase not rejected");

  erase_start_a: assert property (
    take_erase_blk && !I_PROG_PROTECT |=> O_MEM_WE
      && O_MEM_ADDR == $past(first_addr))
    else $error("block erase starts at wrong address");

  erase_bound_a: assert property (
    O_MEM_WE && O_MEM_ADDR == u_walker.last |=> !O_MEM_WE)
    else $error("erase runs past block end");

  full_erase_a: assert property (
    take_erase_full |=> O_MEM_WE && O_MEM_ADDR == BLK0_FIRST
      && O_SOFTWARE_SECURITY_BYTE == CFG_DEFAULT && !O_TX_VALID)
    else $error("full erase did not start or errored");

  erase_ack_a: assert property (
    walk_done |=> O_TX_VALID && O_TX_KIND == FRM_WRITE
      && O_TX_LEN == LEN_ANSWER && O_TX_DATA == ANS_OK)
    else $error("erase not acknowledged");

  wdt_halt_a: assert property (
    take_wdt |=> (O_WDT_ENABLE && !O_RX_READY) [*4])
    else $error("watchdog start not held");

  jump_a: assert property (
    take_jump |=> O_JUMP && O_JUMP_ADDR == {$past(I_RX_DATA2),
      $past(I_RX_DATA3)} && !O_WDT_ENABLE ##0 no_answer_s)
    else $error("jump missing or answered");

  bad_select_a: assert property (
    take_bad_erase |=> O_RX_READY && !O_MEM_WE ##0 no_answer_s)
    else $error("unknown erase selector acted on");

endmodule // cbh_command_handler
`default_nettype wire

// File: verification/cbh_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module cbh_host_model
  import cbh_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Answer pacing
  input wire logic i_slow,
  // Frame towards the block
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output logic [1:0] o_rx_kind,
  output logic [3:0] o_rx_len,
  output logic [31:0] o_rx_data,
  // Answer from the block
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic [1:0] i_tx_kind,
  input wire logic [3:0] i_tx_len,
  input wire logic [7:0] i_tx_data,
  // Last answer taken
  output logic [15:0] o_ans_count,
  output logic [1:0] o_ans_kind,
  output logic [3:0] o_ans_len,
  output logic [7:0] o_ans_data
);
  logic [1:0] pace;

  // Idle lines before the first frame
  initial begin
    o_rx_valid = 1'b0;
    o_rx_kind = FRM_NONE;
    o_rx_len = 4'h0;
    o_rx_data = 32'h0;
  end

  // One whole frame, held until taken; data0 in the top byte
  task automatic send(input logic [1:0] kind, input logic [3:0] len,
                      input logic [31:0] data);
    @(posedge i_clock);
    o_rx_valid <= 1'b1;
    o_rx_kind <= kind;
    o_rx_len <= len;
    o_rx_data <= data;
    do @(posedge i_clock); while (i_rx_ready !== 1'b1);
    o_rx_valid <= 1'b0;
    // Released lines flip so a stale byte can never look valid
    o_rx_kind <= ~kind;
    o_rx_len <= ~len;
    o_rx_data <= ~data;
  endtask

  // Slow mode takes an answer one cycle in four, like a busy link
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      pace <= 2'h0;
    end else begin
      pace <= pace + 2'h1;
    end
  end
  assign o_tx_ready = !i_slow || (pace == 2'h3);

  // Record each answer at its handshake edge
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_ans_count <= 16'h0;
      o_ans_kind <= FRM_NONE;
      o_ans_len <= 4'h0;
      o_ans_data <= 8'h0;
    end else if (i_tx_valid && o_tx_ready) begin
      o_ans_count <= o_ans_count + 16'h1;
      o_ans_kind <= i_tx_kind;
      o_ans_len <= i_tx_len;
      o_ans_data <= i_tx_data;
    end
  end
endmodule // cbh_host_model
`default_nettype wire

// File: verification/can_boot_command_handler_tb.sv
`timescale 1ns/1ns
`default_nettype none
module can_boot_command_handler_tb import cbh_pkg::*; ;
  localparam logic [7:0] SEL [3] = '{SEL_BLK0, SEL_BLK1, SEL_BLK2};
  localparam logic [14:0] LO [3] = '{BLK0_FIRST, BLK1_FIRST, BLK2_FIRST};
  localparam logic [14:0] HI [3] = '{BLK0_LAST, BLK1_LAST, BLK2_LAST};
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic session, rd_prot, pg_prot, slow, rx_valid, rx_ready;
  logic tx_valid, tx_ready, mem_we, wdt, jump;
  logic [1:0] rx_kind, tx_kind, a_kind;
  logic [3:0] rx_len, tx_len, a_len;
  logic [31:0] rx_data;
  logic [7:0] cfg_value, cfg_group, cfg_item, tx_data, mem_data, a_data;
  logic [7:0] boot_st, boot_vec, sec_byte;
  logic [14:0] mem_addr, lo, hi;
  logic [15:0] jump_addr, jaddr, a_count, got_n;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int writes, bad_data, jumps;

  always #5 clock = ~clock;

  cbh_command_handler cbh_command_handler_inst (.I_CLOCK(clock),
    .I_RESET(reset), .I_RX_VALID(rx_valid), .O_RX_READY(rx_ready),
    .I_RX_KIND(rx_kind), .I_RX_LEN(rx_len), .I_RX_DATA0(rx_data[31:24]),
    .I_RX_DATA1(rx_data[23:16]), .I_RX_DATA2(rx_data[15:8]),
    .I_RX_DATA3(rx_data[7:0]), .I_SESSION_OPEN(session),
    .I_READ_PROTECT(rd_prot), .I_PROG_PROTECT(pg_prot),
    .O_CFG_GROUP(cfg_group), .O_CFG_ITEM(cfg_item), .I_CFG_VALUE(cfg_value),
    .O_TX_VALID(tx_valid), .I_TX_READY(tx_ready), .O_TX_KIND(tx_kind),
    .O_TX_LEN(tx_len), .O_TX_DATA(tx_data), .O_MEM_WE(mem_we),
    .O_MEM_ADDR(mem_addr), .O_MEM_DATA(mem_data), .O_WDT_ENABLE(wdt),
    .O_JUMP(jump), .O_JUMP_ADDR(jump_addr), .O_BOOT_STATUS_BYTE(boot_st),
    .O_SOFTWARE_BOOT_VECTOR(boot_vec), .O_SOFTWARE_SECURITY_BYTE(sec_byte));

  cbh_host_model cbh_host_model_inst (.i_clock(clock), .i_reset(reset),
    .i_slow(slow), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready),
    .o_rx_kind(rx_kind), .o_rx_len(rx_len), .o_rx_data(rx_data),
    .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .i_tx_kind(tx_kind),
    .i_tx_len(tx_len), .i_tx_data(tx_data), .o_ans_count(a_count),
    .o_ans_kind(a_kind), .o_ans_len(a_len), .o_ans_data(a_data));

  // Verdict and end of run, shared with the hang guard
  task automatic results();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Answer count of the last command, then the fields of the answer
  task automatic check_ans(input logic [15:0] n, input logic [1:0] k,
                           input logic [3:0] l, input logic [7:0] d);
    check_val(got_n, n);
    if (n != 16'h0) begin
      check_val({a_kind, a_len, a_data}, {2'h0, k, l, d});
    end
  endtask

  // Send a frame, then wait a bounded time for at most one answer
  task automatic cmd(input logic [1:0] k, input logic [3:0] l,
                     input logic [31:0] d, input int bound);
    logic [15:0] n0;
    n0 = a_count;
    writes = 0;
    bad_data = 0;
    jumps = 0;
    lo = 15'h7fff;
    hi = 15'h0;
    cbh_host_model_inst.send(k, l, d);
    for (int i = 0; i < bound && a_count == n0; i++) @(posedge clock);
    repeat (4) @(posedge clock);
    got_n = a_count - n0;
  endtask

  // Erase walk span, erased data, jump pulses and the hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (mem_we === 1'b1) begin
      writes <= writes + 1;
      if (mem_addr < lo) lo <= mem_addr;
      if (mem_addr > hi) hi <= mem_addr;
      if (mem_data !== ERASED_BYTE) bad_data <= bad_data + 1;
    end
    if (jump === 1'b1) begin
      jumps <= jumps + 1;
      jaddr <= jump_addr;
    end
    // Four erases need about 66k cycles; far beyond that is a hang
    if (cycles == 80000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    session = 1'b0;
    rd_prot = 1'b0;
    pg_prot = 1'b0;
    slow = 1'b0;
    cfg_value = 8'ha7;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    check_val({boot_st, boot_vec}, 16'hffff);
    check_val({sec_byte, 6'h0, tx_valid, rx_ready}, 16'hff01);
    // Closed session swallows read and erase frames alike
    cmd(FRM_READ, LEN_REQ2, {GRP_BOOT, ITEM_VEC, 16'h0}, 20);
    check_ans(16'h0, FRM_NONE, 4'h0, 8'h0);
    check_val({cfg_group, cfg_item}, 16'h0);
    cmd(FRM_WRITE, LEN_REQ2, {CMD_ERASE, SEL_BLK0, 16'h0}, 20);
    check_ans(16'h0, FRM_NONE, 4'h0, 8'h0);
    check_val(16'(writes), 16'h0);
    session <= 1'b1;
    slow <= 1'b1;
    // Reads answered over a stalling link, every boot byte item
    cmd(FRM_READ, LEN_REQ2, {GRP_BOOT, ITEM_VEC, 16'h0}, 40);
    check_ans(16'h1, FRM_READ, LEN_ANSWER, CFG_DEFAULT);
    cmd(FRM_READ, LEN_REQ2, {GRP_BOOT, ITEM_STAT, 16'h0}, 40);
    check_ans(16'h1, FRM_READ, LEN_ANSWER, CFG_DEFAULT);
    cmd(FRM_READ, LEN_REQ2, {GRP_BOOT, ITEM_SEC, 16'h0}, 40);
    check_ans(16'h1, FRM_READ, LEN_ANSWER, CFG_DEFAULT);
    cmd(FRM_READ, LEN_REQ2, 32'h0002_0000, 40);
    check_ans(16'h1, FRM_READ, LEN_ANSWER, 8'ha7);
    check_val({cfg_group, cfg_item}, 16'h0002);
    slow <= 1'b0;
    rd_prot <= 1'b1;
    cmd(FRM_READ, LEN_REQ2, 32'h0002_0000, 40);
    check_ans(16'h1, FRM_ERROR, LEN_ANSWER, ERR_SECURITY);
    rd_prot <= 1'b0;
    pg_prot <= 1'b1;
    cmd(FRM_WRITE, LEN_REQ2, {CMD_ERASE, SEL_BLK1, 16'h0}, 40);
    check_ans(16'h1, FRM_ERROR, LEN_ANSWER, ERR_SECURITY);
    check_val(16'(writes), 16'h0);
    // Full erase runs while protected and restores the boot bytes
    cmd(FRM_WRITE, LEN_REQ2, {CMD_ERASE, SEL_FULL, 16'h0}, 32800);
    check_ans(16'h1, FRM_WRITE, LEN_ANSWER, ANS_OK);
    check_val(16'(writes), 16'h8000);
    check_val({1'b0, hi}, {1'b0, MEM_LAST});
    check_val({lo[7:0], boot_st}, 16'h00ff);
    check_val({boot_vec, sec_byte}, 16'hffff);
    pg_prot <= 1'b0;
    for (int b = 0; b < 3; b++) begin
      cmd(FRM_WRITE, LEN_REQ2, {CMD_ERASE, SEL[b], 16'h0}, 16400);
      check_ans(16'h1, FRM_WRITE, LEN_ANSWER, ANS_OK);
      check_val({1'b0, lo}, {1'b0, LO[b]});
      check_val({1'b0, hi}, {1'b0, HI[b]});
      check_val(16'(writes + bad_data), 16'(HI[b] - LO[b] + 15'h1));
    end
    // Unknown selector does nothing at all
    cmd(FRM_WRITE, LEN_REQ2, {CMD_ERASE, 8'h10, 16'h0}, 30);
    check_ans(16'h0, FRM_NONE, 4'h0, 8'h0);
    check_val(16'(writes), 16'h0);
    cmd(FRM_WRITE, LEN_JUMP, {CMD_START_JMP, OPT_START_JMP, 16'h1234}, 30);
    check_ans(16'h0, FRM_NONE, 4'h0, 8'h0);
    check_val(16'(jumps), 16'h1);
    check_val(jaddr, 16'h1234);
    check_val({15'h0, wdt}, 16'h0);
    cmd(FRM_WRITE, LEN_REQ2, {CMD_START_RST, OPT_START_RST, 16'h0}, 30);
    check_ans(16'h0, FRM_NONE, 4'h0, 8'h0);
    check_val({14'h0, wdt, rx_ready}, 16'h2);
    // Watchdog reset ends the halt state
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    check_val({14'h0, wdt, rx_ready}, 16'h1);
    results();
  end
endmodule // can_boot_command_handler_tb
`default_nettype wire
